// ---- rtl/srrp_core.sv ----
// stored-command interpreter for the remote end of the serial link
`timescale 1ns/1ps
`default_nettype none
`include "srrp_cfg.svh"
// Behaviour
// - lists start on pitch, may run to table end
// - list start is number times pitch
// - include bit clear: write data from stream
// - header top bits 10 selects list 0-63
// - zero byte at header place ends list
// - discovery, unit number, process data are hardwired
// - programmable lists are optional, provided anyway
// - discovery answers six bytes in order
// - discovery code is a parameter
// - unit number four bytes, lsb first
// - discovery data follows software and hardware mode
// - receive size includes fault byte
// - process data: outputs in, fault plus inputs out
// - exchange sizes match discovery announcement
// - device appends crc, 00 when no data
// - character gap over timeout resets parser
// - setup mode gap limit 25.5 characters
// - operate mode uses programmed 4 character timeout
// - timeout set by local write, characters
module srrp_core #(
    parameter int TABLE_BYTES = 64 * `SRRP_PITCH,
    parameter int REPLY_BYTES = 64,
    parameter int HALF_CHAR_CLKS = `SRRP_HALF_CHAR_CLKS,
    parameter logic [7:0] DISC_CODE = `SRRP_DISC_CODE,
    parameter logic [7:0] UNIT_CODE = `SRRP_UNIT_CODE,
    parameter logic [7:0] PD_CODE = `SRRP_PD_CODE
) (
    input wire logic REF_CLK,
    input wire logic RSTN,
    input wire logic SETUP_MODE,
    input wire logic [1:0] SW_MODE,
    input wire logic HW_MODE,
    input wire srrp_pkg::srrp_desc_s [7:0] MODE_DESC,
    input wire logic [31:0] UNIT_NUMBER,
    input wire logic [7:0] FAULT_BYTE,
    input wire logic RX_VALID,
    input wire logic [7:0] RX_DATA,
    output logic TX_VALID,
    output logic [7:0] TX_DATA,
    input wire logic TX_READY,
    output srrp_pkg::srrp_mem_s MEM_REQ,
    input wire logic [7:0] MEM_RDATA,
    output logic PD_OUT_VALID,
    output logic [7:0] PD_OUT_IDX,
    output logic [7:0] PD_OUT_DATA,
    output logic PD_OUT_COMMIT,
    output logic [7:0] PD_IN_IDX,
    input wire logic [7:0] PD_IN_DATA,
    input wire logic TBL_WE,
    input wire logic [15:0] TBL_ADDR,
    input wire logic [7:0] TBL_WDATA,
    output logic TABLE_ACCESS,
    output logic [7:0] CMD_TIMEOUT,
    output logic CRC_ERROR,
    output logic TIMEOUT_ERROR
);
    import srrp_pkg::*;

    localparam int TW = $clog2(TABLE_BYTES);
    localparam int HW = $clog2(HALF_CHAR_CLKS + 1);
    localparam logic [TW-1:0] PTR_LAST = TW'(TABLE_BYTES - 1);

    ////////////////////////////////////////////////////////////////////////////
    srrp_state_e state_ff, nxt_state;
    srrp_kind_e kind_ff, nxt_kind;
    logic [TW-1:0] ptr_ff, nxt_ptr;
    logic end_ff, nxt_end;
    logic [15:0] addr_ff, nxt_addr;
    logic [7:0] hdr_ff, nxt_hdr;
    logic [3:0] cnt_ff, nxt_cnt;
    logic [7:0] len_ff, nxt_len;
    logic [7:0] idx_ff, nxt_idx;
    logic [7:0] rx_crc_ff, nxt_rx_crc;
    logic [7:0] tx_crc_ff, nxt_tx_crc;
    logic [7:0] pend_ff, nxt_pend;
    logic have_ff, nxt_have;
    logic tx_valid_ff, nxt_tx_valid;
    logic [7:0] tx_data_ff, nxt_tx_data;
    srrp_mem_s mem_ff, nxt_mem;
    logic pdv_ff, nxt_pdv;
    logic [7:0] pdi_ff, nxt_pdi;
    logic [7:0] pdd_ff, nxt_pdd;
    logic commit_ff, nxt_commit;
    logic [7:0] tmo_ff, nxt_tmo;
    logic acc_ff, nxt_acc;
    logic [8:0] gap_ff, nxt_gap;
    logic [HW-1:0] half_ff, nxt_half;
    logic crc_err_ff, nxt_crc_err;
    logic tmo_err_ff, nxt_tmo_err;
    logic [7:0] buf_ff [REPLY_BYTES];
    logic [7:0] nxt_buf [REPLY_BYTES];
    logic [7:0] tbl_ff [TABLE_BYTES];

    srrp_desc_s desc;
    logic [7:0] tbyte;
    logic [7:0] rbyte;
    logic [3:0] dsize;
    logic [3:0] off;
    logic [8:0] gap_limit;
    logic tx_free;
    logic take;

    assign desc = MODE_DESC[{HW_MODE, SW_MODE}];
    assign tbyte = tbl_ff[ptr_ff];
    assign dsize = 4'h1 << hdr_ff[1:0];
    assign off = dsize - cnt_ff;
    assign tx_free = !tx_valid_ff || TX_READY;
    assign PD_IN_IDX = idx_ff - 8'h01;

    // reply source picked per byte so no copy loop is needed before sending
    always_comb begin
        rbyte = 8'h00;
        unique case (kind_ff)
            K_DISC: begin
                unique case (idx_ff[2:0])
                    3'h0: rbyte = desc.rx_size;
                    3'h1: rbyte = desc.tx_size;
                    3'h2: rbyte = desc.parameter_table_pointer[7:0];
                    3'h3: rbyte = desc.parameter_table_pointer[15:8];
                    3'h4: rbyte = desc.mode_table_pointer[7:0];
                    default: rbyte = desc.mode_table_pointer[15:8];
                endcase
            end
            K_UNIT: rbyte = UNIT_NUMBER[{idx_ff[1:0], 3'h0} +: 8];
            K_PD: rbyte = (idx_ff == 8'h00) ? FAULT_BYTE : PD_IN_DATA;
            K_STORED: rbyte = buf_ff[idx_ff[$clog2(REPLY_BYTES)-1:0]];
            K_LOCAL: rbyte = 8'h00;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        nxt_state = state_ff;
        nxt_kind = kind_ff;
        nxt_ptr = ptr_ff;
        nxt_end = end_ff;
        nxt_addr = addr_ff;
        nxt_hdr = hdr_ff;
        nxt_cnt = cnt_ff;
        nxt_len = len_ff;
        nxt_idx = idx_ff;
        nxt_rx_crc = rx_crc_ff;
        nxt_tx_crc = tx_crc_ff;
        nxt_tx_valid = tx_valid_ff && !TX_READY;
        nxt_tx_data = tx_data_ff;
        nxt_mem = '0;
        nxt_mem.addr = mem_ff.addr;
        nxt_mem.wdata = mem_ff.wdata;
        nxt_pdv = 1'b0;
        nxt_pdi = pdi_ff;
        nxt_pdd = pdd_ff;
        nxt_commit = 1'b0;
        nxt_tmo = tmo_ff;
        nxt_acc = acc_ff;
        nxt_crc_err = 1'b0;
        nxt_tmo_err = 1'b0;
        nxt_buf = buf_ff;
        take = 1'b0;
        // half-character enable from the reference clock
        nxt_half = half_ff + HW'(1);
        nxt_gap = gap_ff;
        if (half_ff == HW'(HALF_CHAR_CLKS - 1)) begin
            nxt_half = '0;
            if (gap_ff != 9'h1FF) begin
                nxt_gap = gap_ff + 9'h001;
            end
        end
        if (RX_VALID) begin
            nxt_gap = 9'h000;
        end
        gap_limit = SETUP_MODE ? `SRRP_SETUP_GAP_HALF : {tmo_ff, 1'b0};
        unique case (state_ff)
            ST_IDLE: begin
                if (have_ff) begin
                    take = 1'b1;
                    nxt_rx_crc = srrp_crc8(8'h00, pend_ff);
                    nxt_len = 8'h00;
                    nxt_idx = 8'h00;
                    nxt_end = 1'b0;
                    nxt_hdr = pend_ff;
                    nxt_state = ST_CRC;
                    if (pend_ff == DISC_CODE) begin
                        nxt_kind = K_DISC;
                    end else if (pend_ff == UNIT_CODE) begin
                        nxt_kind = K_UNIT;
                    end else if (pend_ff == PD_CODE) begin
                        nxt_kind = K_PD;
                        if (desc.tx_size != 8'h00) begin
                            nxt_state = ST_PD_OUT;
                        end
                    end else if (pend_ff[7:6] == `SRRP_STORED_TYPE) begin
                        nxt_kind = K_STORED;
                        nxt_ptr = TW'(32'(pend_ff[5:0]) * `SRRP_PITCH);
                        nxt_state = ST_FETCH;
                    end else if (pend_ff == `SRRP_SET_TIMEOUT
                                 || pend_ff == `SRRP_SET_ACCESS) begin
                        nxt_kind = K_LOCAL;
                        nxt_state = ST_LOCAL;
                    end else begin
                        nxt_state = ST_DROP;
                    end
                end
            end
            ST_LOCAL: begin
                if (have_ff) begin
                    take = 1'b1;
                    nxt_rx_crc = srrp_crc8(rx_crc_ff, pend_ff);
                    nxt_addr[7:0] = pend_ff;
                    nxt_state = ST_CRC;
                end
            end
            ST_PD_OUT: begin
                if (have_ff) begin
                    take = 1'b1;
                    nxt_rx_crc = srrp_crc8(rx_crc_ff, pend_ff);
                    nxt_pdv = 1'b1;
                    nxt_pdi = idx_ff;
                    nxt_pdd = pend_ff;
                    nxt_idx = idx_ff + 8'h01;
                    if (idx_ff + 8'h01 == desc.tx_size) begin
                        nxt_state = ST_CRC;
                    end
                end
            end
            ST_FETCH: begin
                if (end_ff || tbyte == `SRRP_TERMINATOR
                    || tbyte[7:6] != `SRRP_RW_TYPE) begin
                    nxt_state = ST_CRC;
                end else begin
                    nxt_hdr = tbyte;
                    nxt_cnt = 4'h1 << tbyte[1:0];
                    nxt_state = tbyte[`SRRP_HDR_AS] ? ST_ADDR_LO : ST_DATA;
                end
            end
            ST_ADDR_LO: begin
                nxt_addr[7:0] = tbyte;
                nxt_state = end_ff ? ST_CRC : ST_ADDR_HI;
            end
            ST_ADDR_HI: begin
                nxt_addr[15:8] = tbyte;
                nxt_state = end_ff ? ST_CRC : ST_DATA;
            end
            ST_DATA: begin
                nxt_mem.addr = addr_ff + 16'(off);
                if (!hdr_ff[`SRRP_HDR_WR]) begin
                    nxt_mem.re = 1'b1;
                    nxt_state = ST_RD;
                end else if (hdr_ff[`SRRP_HDR_RID]) begin
                    if (end_ff) begin
                        nxt_state = ST_CRC;
                    end else begin
                        nxt_mem.we = 1'b1;
                        nxt_mem.wdata = tbyte;
                        nxt_state = ST_RD;
                    end
                end else if (have_ff) begin
                    take = 1'b1;
                    nxt_rx_crc = srrp_crc8(rx_crc_ff, pend_ff);
                    nxt_mem.we = 1'b1;
                    nxt_mem.wdata = pend_ff;
                    nxt_state = ST_RD;
                end
            end
            ST_RD: begin
                if (mem_ff.re && len_ff < 8'(REPLY_BYTES)) begin
                    nxt_buf[len_ff[$clog2(REPLY_BYTES)-1:0]] = MEM_RDATA;
                    nxt_len = len_ff + 8'h01;
                end
                nxt_cnt = cnt_ff - 4'h1;
                nxt_state = ST_DATA;
                if (cnt_ff == 4'h1) begin
                    nxt_state = ST_FETCH;
                    if (hdr_ff[`SRRP_HDR_AI]) begin
                        nxt_addr = addr_ff + 16'(dsize);
                    end
                end
            end
            ST_CRC: begin
                if (have_ff) begin
                    take = 1'b1;
                    nxt_idx = 8'h00;
                    nxt_tx_crc = 8'h00;
                    if (pend_ff == rx_crc_ff) begin
                        nxt_state = ST_SEND;
                        unique case (kind_ff)
                            K_DISC: nxt_len = `SRRP_DISC_LEN;
                            K_UNIT: nxt_len = `SRRP_UNIT_LEN;
                            K_PD: nxt_len = desc.rx_size;
                            K_STORED: nxt_len = len_ff;
                            K_LOCAL: nxt_len = 8'h00;
                        endcase
                        nxt_commit = (kind_ff == K_PD);
                        if (kind_ff == K_LOCAL && hdr_ff == `SRRP_SET_TIMEOUT) begin
                            nxt_tmo = addr_ff[7:0];
                        end
                        if (kind_ff == K_LOCAL && hdr_ff == `SRRP_SET_ACCESS) begin
                            nxt_acc = (addr_ff[7:0] != 8'h00);
                        end
                    end else begin
                        nxt_crc_err = 1'b1;
                        nxt_state = ST_IDLE;
                    end
                end
            end
            ST_SEND: begin
                if (tx_free) begin
                    nxt_tx_valid = 1'b1;
                    if (idx_ff == len_ff) begin
                        nxt_tx_data = (len_ff == 8'h00) ? `SRRP_EMPTY_CRC : tx_crc_ff;
                        nxt_state = ST_IDLE;
                    end else begin
                        nxt_tx_data = rbyte;
                        nxt_tx_crc = srrp_crc8(tx_crc_ff, rbyte);
                        nxt_idx = idx_ff + 8'h01;
                    end
                end
            end
            ST_DROP: begin
                take = have_ff;
            end
        endcase
        // table pointer advances on every consumed table byte, stops at the end
        if ((state_ff == ST_FETCH && nxt_state != ST_CRC) || state_ff == ST_ADDR_LO
            || state_ff == ST_ADDR_HI || (state_ff == ST_DATA && nxt_mem.we
            && hdr_ff[`SRRP_HDR_RID])) begin
            if (ptr_ff == PTR_LAST) begin
                nxt_end = 1'b1;
            end else begin
                nxt_ptr = ptr_ff + TW'(1);
            end
        end
        // a gap aborts in every state except idle and send, list walking included
        if (state_ff != ST_IDLE && state_ff != ST_SEND && !RX_VALID
            && gap_ff >= gap_limit) begin
            nxt_state = ST_IDLE;
            nxt_tmo_err = (state_ff != ST_DROP);
            take = 1'b1;
        end
        // a byte arriving while the held one is taken is kept
        nxt_pend = RX_VALID ? RX_DATA : pend_ff;
        nxt_have = RX_VALID || (have_ff && !take);
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            state_ff <= ST_IDLE;
            kind_ff <= K_STORED;
            ptr_ff <= '0;
            end_ff <= 1'b0;
            addr_ff <= 16'h0000;
            hdr_ff <= 8'h00;
            cnt_ff <= 4'h0;
            len_ff <= 8'h00;
            idx_ff <= 8'h00;
            rx_crc_ff <= 8'h00;
            tx_crc_ff <= 8'h00;
            pend_ff <= 8'h00;
            have_ff <= 1'b0;
            tx_valid_ff <= 1'b0;
            tx_data_ff <= 8'h00;
            mem_ff <= '0;
            pdv_ff <= 1'b0;
            pdi_ff <= 8'h00;
            pdd_ff <= 8'h00;
            commit_ff <= 1'b0;
            tmo_ff <= `SRRP_TIMEOUT_RST;
            acc_ff <= 1'b0;
            gap_ff <= 9'h000;
            half_ff <= '0;
            crc_err_ff <= 1'b0;
            tmo_err_ff <= 1'b0;
            buf_ff <= '{default: 8'h00};
        end else begin
            state_ff <= nxt_state;
            kind_ff <= nxt_kind;
            ptr_ff <= nxt_ptr;
            end_ff <= nxt_end;
            addr_ff <= nxt_addr;
            hdr_ff <= nxt_hdr;
            cnt_ff <= nxt_cnt;
            len_ff <= nxt_len;
            idx_ff <= nxt_idx;
            rx_crc_ff <= nxt_rx_crc;
            tx_crc_ff <= nxt_tx_crc;
            pend_ff <= nxt_pend;
            have_ff <= nxt_have;
            tx_valid_ff <= nxt_tx_valid;
            tx_data_ff <= nxt_tx_data;
            mem_ff <= nxt_mem;
            pdv_ff <= nxt_pdv;
            pdi_ff <= nxt_pdi;
            pdd_ff <= nxt_pdd;
            commit_ff <= nxt_commit;
            tmo_ff <= nxt_tmo;
            acc_ff <= nxt_acc;
            gap_ff <= nxt_gap;
            half_ff <= nxt_half;
            crc_err_ff <= nxt_crc_err;
            tmo_err_ff <= nxt_tmo_err;
            buf_ff <= nxt_buf;
        end
    end

    // table storage carries no reset; loading only while access is enabled
    always_ff @(posedge REF_CLK) begin
        if (TBL_WE && acc_ff && TBL_ADDR < 16'(TABLE_BYTES)) begin
            tbl_ff[TBL_ADDR[TW-1:0]] <= TBL_WDATA;
        end
    end

    assign TX_VALID = tx_valid_ff;
    assign TX_DATA = tx_data_ff;
    assign MEM_REQ = mem_ff;
    assign PD_OUT_VALID = pdv_ff;
    assign PD_OUT_IDX = pdi_ff;
    assign PD_OUT_DATA = pdd_ff;
    assign PD_OUT_COMMIT = commit_ff;
    assign TABLE_ACCESS = acc_ff;
    assign CMD_TIMEOUT = tmo_ff;
    assign CRC_ERROR = crc_err_ff;
    assign TIMEOUT_ERROR = tmo_err_ff;
endmodule
`default_nettype wire

// ---- rtl/srrp_cfg.svh ----
// constants for the serial remote stored-command interpreter
`ifndef SRRP_CFG_SVH
`define SRRP_CFG_SVH
`define SRRP_CLK_HZ 25000000
`define SRRP_BAUD 115200
`define SRRP_BITS_PER_CHAR 10
`define SRRP_HALF_CHAR_CLKS ((`SRRP_CLK_HZ * `SRRP_BITS_PER_CHAR) / (2 * `SRRP_BAUD))
`define SRRP_SETUP_GAP_HALF 9'h033
`define SRRP_TIMEOUT_RST 8'h04
`define SRRP_PITCH 8
`define SRRP_STORED_TYPE 2'h2
`define SRRP_RW_TYPE 2'h1
`define SRRP_HDR_WR 5
`define SRRP_HDR_RID 4
`define SRRP_HDR_AI 3
`define SRRP_HDR_AS 2
`define SRRP_DISC_CODE 8'hBB
`define SRRP_UNIT_CODE 8'hBC
`define SRRP_PD_CODE 8'hBD
`define SRRP_SET_ACCESS 8'hEA
`define SRRP_SET_TIMEOUT 8'hEB
`define SRRP_TERMINATOR 8'h00
`define SRRP_EMPTY_CRC 8'h00
`define SRRP_CRC_POLY 8'h8C
`define SRRP_DISC_LEN 8'h06
`define SRRP_UNIT_LEN 8'h04
`endif

// ---- rtl/srrp_pkg.sv ----
// types and crc helper for the serial remote stored-command interpreter
`include "srrp_cfg.svh"
package srrp_pkg;
    typedef enum logic [3:0] {
        ST_IDLE, ST_LOCAL, ST_PD_OUT, ST_FETCH, ST_ADDR_LO, ST_ADDR_HI,
        ST_DATA, ST_RD, ST_CRC, ST_SEND, ST_DROP
    } srrp_state_e;
    typedef enum logic [2:0] {K_STORED, K_DISC, K_UNIT, K_PD, K_LOCAL} srrp_kind_e;
    typedef struct packed {
        logic [7:0] rx_size;
        logic [7:0] tx_size;
        logic [15:0] parameter_table_pointer;
        logic [15:0] mode_table_pointer;
    } srrp_desc_s;
    typedef struct packed {
        logic we;
        logic re;
        logic [15:0] addr;
        logic [7:0] wdata;
    } srrp_mem_s;
    // reflected form, lsb first, zero start
    function automatic logic [7:0] srrp_crc8(input logic [7:0] crc, input logic [7:0] d);
        logic [7:0] c;
        c = crc;
        for (int i = 0; i < 8; i++) begin
            if (c[0] ^ d[i]) begin
                c = (c >> 1) ^ `SRRP_CRC_POLY;
            end else begin
                c = c >> 1;
            end
        end
        return c;
    endfunction
endpackage

// ---- tb/srrp_host_model.sv ----
// host-side model that takes reply bytes off the serial transmit port
`timescale 1ns/1ps
`default_nettype none
module srrp_host_model (
    input wire logic clk,
    input wire logic rstn,
    input wire logic slow,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    output var logic tx_ready,
    output var logic got,
    output var logic [7:0] got_data
);
    logic [1:0] ph_ff;
    // slow mode accepts one cycle in four, so the sender must hold its byte
    always @(negedge clk) begin
        ph_ff <= rstn ? ph_ff + 2'h1 : 2'h0;
        tx_ready <= rstn && (!slow || ph_ff == 2'h0);
    end
    always @(posedge clk) begin
        got <= tx_valid && tx_ready && rstn;
        got_data <= tx_data;
    end
endmodule
`default_nettype wire

// ---- tb/srrp_core_monitor.sv ----
// assertion checker on the interpreter ports
`timescale 1ns/1ps
`default_nettype none
module srrp_core_monitor #(
    parameter int HALF_CHAR_CLKS = 4
) (
    input wire logic REF_CLK,
    input wire logic RSTN,
    input wire logic SETUP_MODE,
    input wire logic [1:0] SW_MODE,
    input wire logic HW_MODE,
    input wire srrp_pkg::srrp_desc_s [7:0] MODE_DESC,
    input wire logic RX_VALID,
    input wire logic TX_VALID,
    input wire logic [7:0] TX_DATA,
    input wire logic TX_READY,
    input wire srrp_pkg::srrp_mem_s MEM_REQ,
    input wire logic PD_OUT_VALID,
    input wire logic [7:0] PD_OUT_IDX,
    input wire logic PD_OUT_COMMIT,
    input wire logic [7:0] CMD_TIMEOUT,
    input wire logic CRC_ERROR,
    input wire logic TIMEOUT_ERROR
);
    import srrp_pkg::*;
    logic [15:0] gap_ff;
    int lim;
    default clocking @(posedge REF_CLK);
    endclocking
    default disable iff (!RSTN);
    ////////////////////////////////////////////////////////////////////////
    always_comb lim = (SETUP_MODE ? 51 : 2 * int'(CMD_TIMEOUT)) * HALF_CHAR_CLKS;
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            gap_ff <= 16'h0000;
        end else begin
            gap_ff <= RX_VALID ? 16'h0000 : gap_ff + {15'h0000, gap_ff != 16'hFFFF};
        end
    end
    ////////////////////////////////////////////////////////////////////////
    reset_vals_a: assert property ($rose(RSTN) |-> CMD_TIMEOUT == 8'h04 && !TX_VALID)
        else $error("timeout or transmit wrong after reset");
    tx_hold_a: assert property (TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA))
        else $error("reply byte dropped or changed while stalled");
    crc_quiet_a: assert property (CRC_ERROR |=> !TX_VALID [*4])
        else $error("reply sent after bad check byte");
    crc_commit_a: assert property (CRC_ERROR |-> !PD_OUT_COMMIT ##1 !PD_OUT_COMMIT)
        else $error("process data committed with bad check byte");
    gap_min_a: assert property (TIMEOUT_ERROR |-> int'(gap_ff) + 8 >= lim)
        else $error("parser reset before gap limit");
    rd_succ_a: assert property (MEM_REQ.re && $past(MEM_REQ.re, 2) |->
        MEM_REQ.addr == $past(MEM_REQ.addr, 2) + 16'h0001)
        else $error("multi byte read not on successive addresses");
    mem_excl_a: assert property (MEM_REQ.we |-> !MEM_REQ.re)
        else $error("read and write in one cycle");
    pd_index_a: assert property (PD_OUT_VALID |->
        PD_OUT_IDX < MODE_DESC[{HW_MODE, SW_MODE}].tx_size)
        else $error("process output index beyond announced size");
endmodule
bind srrp_core srrp_core_monitor #(.HALF_CHAR_CLKS(HALF_CHAR_CLKS)) mon_u (
    .REF_CLK(REF_CLK), .RSTN(RSTN), .SETUP_MODE(SETUP_MODE), .SW_MODE(SW_MODE),
    .HW_MODE(HW_MODE), .MODE_DESC(MODE_DESC), .RX_VALID(RX_VALID), .TX_VALID(TX_VALID),
    .TX_DATA(TX_DATA), .TX_READY(TX_READY), .MEM_REQ(MEM_REQ), .PD_OUT_VALID(PD_OUT_VALID),
    .PD_OUT_IDX(PD_OUT_IDX), .PD_OUT_COMMIT(PD_OUT_COMMIT), .CMD_TIMEOUT(CMD_TIMEOUT),
    .CRC_ERROR(CRC_ERROR), .TIMEOUT_ERROR(TIMEOUT_ERROR));
`default_nettype wire

// ---- tb/srrp_core_bench.sv ----
// self-checking bench for the stored-command interpreter
`timescale 1ns/1ps
`default_nettype none
module srrp_core_bench;
    import srrp_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic setup = 1'b1;
    logic hw = 1'b0;
    logic [1:0] sw = 2'h0;
    logic rxv = 1'b0;
    logic twe = 1'b0;
    logic slow = 1'b0;
    logic [15:0] ta = 16'h0000;
    logic [7:0] rxd = 8'h00;
    logic [7:0] twd = 8'h00;
    logic [31:0] unit, seed = 32'hA388;
    srrp_desc_s [7:0] desc;
    srrp_mem_s mreq;
    logic [7:0] fault, txd, gd, pdo_idx, pdo_d, pdi_idx, cto;
    logic txv, txr, got, pdov, pdoc, tacc, crce, toe;
    logic [7:0] exp_q[$], b[$], rq[$], none[$], pd_exp[8];
    logic [23:0] wr_q[$];
    int fails = 0, n_compared = 0, n_crc = 0, n_to = 0, n_commit = 0;
    always #20 clk = ~clk;
    srrp_core #(.HALF_CHAR_CLKS(4)) dut_u (
        .REF_CLK(clk), .RSTN(rstn), .SETUP_MODE(setup), .SW_MODE(sw), .HW_MODE(hw),
        .MODE_DESC(desc), .UNIT_NUMBER(unit), .FAULT_BYTE(fault), .RX_VALID(rxv),
        .RX_DATA(rxd), .TX_VALID(txv), .TX_DATA(txd), .TX_READY(txr), .MEM_REQ(mreq),
        .MEM_RDATA(mreq.addr[7:0] ^ 8'hA5), .PD_OUT_VALID(pdov), .PD_OUT_IDX(pdo_idx),
        .PD_OUT_DATA(pdo_d), .PD_OUT_COMMIT(pdoc), .PD_IN_IDX(pdi_idx),
        .PD_IN_DATA(pdi_idx ^ 8'h3C), .TBL_WE(twe), .TBL_ADDR(ta), .TBL_WDATA(twd),
        .TABLE_ACCESS(tacc), .CMD_TIMEOUT(cto), .CRC_ERROR(crce), .TIMEOUT_ERROR(toe));
    srrp_host_model host_u (.clk(clk), .rstn(rstn), .slow(slow), .tx_valid(txv),
        .tx_data(txd), .tx_ready(txr), .got(got), .got_data(gd));
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    function automatic logic [7:0] crc(input logic [7:0] q[$]);
        logic [7:0] r;
        r = 8'h00;
        foreach (q[i]) begin
            for (int k = 0; k < 8; k++) begin
                r = (r >> 1) ^ ((r[0] ^ q[i][k]) ? 8'h8C : 8'h00);
            end
        end
        return r;
    endfunction
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
        n_compared++;
        if (s !== e) begin
            fails++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic put(input logic [7:0] v);
        @(negedge clk);
        rxv = 1'b1;
        rxd = v;
        @(negedge clk);
        rxv = 1'b0;
        rxd = ~v;
        // one byte per character time: the receive holder keeps only one byte
        repeat (6) @(negedge clk);
    endtask
    // a bad check byte expects silence; otherwise reply plus its check byte
    task automatic cmd(input logic [7:0] h[$], input logic bad, input logic [7:0] r[$],
                       input int gap = 0);
        if (!bad) begin
            exp_q = r;
            exp_q.push_back(crc(r));
        end
        foreach (h[i]) begin
            put(h[i]);
            if (i == 0) repeat (gap) @(negedge clk);
        end
        put(crc(h) ^ {7'h00, bad});
        for (int i = 0; i < 400 && exp_q.size() > 0; i++) @(negedge clk);
        chk("missing reply bytes", 8'h00, 8'(exp_q.size()));
        repeat (6) @(negedge clk);
    endtask
    task automatic load(input logic [15:0] a, input logic [7:0] v[$]);
        foreach (v[i]) begin
            @(negedge clk);
            twe = 1'b1;
            ta = a + 16'(i);
            twd = v[i];
        end
        @(negedge clk);
        twe = 1'b0;
    endtask
    task automatic complete_run();
        $display("compared %0d failed %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        if (got) chk("reply byte", exp_q.size() ? exp_q.pop_front() : ~gd, gd);
        if (mreq.we) wr_q.push_back({mreq.addr, mreq.wdata});
        if (pdov) chk("process out", pd_exp[pdo_idx[2:0]], pdo_d);
        n_crc += int'(crce);
        n_to += int'(toe);
        n_commit += int'(pdoc);
    end
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        complete_run();
    end
    initial begin
        for (int i = 0; i < 8; i++) begin
            seed = xs(seed);
            desc[i] = {{6'h00, seed[1:0]} + 8'h01, {6'h00, seed[3:2]}, seed};
        end
        seed = xs(seed);
        unit = seed;
        fault = seed[15:8];
        repeat (6) @(negedge clk);
        rstn = 1'b1;
        @(negedge clk);
        chk("timeout reset", 8'h04, cto);
        for (int m = 3; m < 8; m += 3) begin
            {hw, sw} = 3'(m);
            cmd('{8'hBB}, 1'b0, '{desc[m].rx_size, desc[m].tx_size, desc[m].parameter_table_pointer[7:0],
                desc[m].parameter_table_pointer[15:8], desc[m].mode_table_pointer[7:0], desc[m].mode_table_pointer[15:8]});
        end
        slow = 1'b1;
        cmd('{8'hBC}, 1'b0, '{unit[7:0], unit[15:8], unit[23:16], unit[31:24]});
        cmd('{8'hEB, 8'h02}, 1'b0, none);
        chk("timeout set", 8'h02, cto);
        cmd('{8'hEA, 8'h01}, 1'b0, none);
        chk("table access", 8'h01, {7'h00, tacc});
        load(16'h0028, '{8'h65, 8'h10, 8'h00, 8'h45, 8'h12, 8'h00, 8'h00});
        load(16'h0030, '{8'h45, 8'h40, 8'h00, 8'h45, 8'h42, 8'h00, 8'h44, 8'h44, 8'h00,
            8'h00});
        cmd('{8'hEA, 8'h00}, 1'b0, none);
        cmd('{8'h85, 8'h55, 8'hCC}, 1'b0, '{8'hB7, 8'hB6});
        for (int i = 0; i < 2; i++) begin
            chk("write addr", 8'(16 + i), wr_q[i][15:8]);
            chk("write data", i ? 8'hCC : 8'h55, wr_q[i][7:0]);
        end
        cmd('{8'h86}, 1'b0, '{8'hE5, 8'hE4, 8'hE7, 8'hE6, 8'hE1});
        b = '{8'hBD};
        for (int i = 0; i < int'(desc[6].tx_size); i++) begin
            seed = xs(seed);
            pd_exp[i] = seed[7:0];
            b.push_back(seed[7:0]);
        end
        rq = '{fault};
        for (int k = 0; k < int'(desc[6].rx_size) - 1; k++) rq.push_back(8'(k) ^ 8'h3C);
        cmd(b, 1'b0, rq);
        chk("commit count", 8'h01, 8'(n_commit));
        cmd('{8'hBB}, 1'b1, none);
        chk("crc errors", 8'h01, 8'(n_crc));
        setup = 1'b0;
        put(8'h85);
        repeat (4) @(negedge clk);
        put(8'h55);
        repeat (40) @(negedge clk);
        chk("operate gap abort", 8'h01, 8'(n_to));
        cmd('{8'hEB, 8'h02}, 1'b0, none);
        setup = 1'b1;
        cmd('{8'h85, 8'h55, 8'hCC}, 1'b0, '{8'hB7, 8'hB6}, 150);
        put(8'h85);
        repeat (260) @(negedge clk);
        chk("setup gap abort", 8'h02, 8'(n_to));
        complete_run();
    end
endmodule
`default_nettype wire
